// file: rtl/dac_ctrl.sv
// Serial register logic of the eight-channel converter.
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.svh"

module dac_ctrl #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 14
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rstn,
  input  wire logic                       i_ce,
  input  wire logic                       i_sclk,
  input  wire logic                       i_cs_n,
  input  wire logic                       i_sdi,
  input  wire logic                       i_wake_pin_n,
  input  wire logic                       i_load_n,
  output logic                            o_sdo,
  output logic                            o_sdo_oe,
  output logic                            o_pass_through,
  output logic [CHANNELS*CODE_W-1:0]      o_latch_code
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================

  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic       sclk_d;
  logic       cs_d;
  logic       load_d;

  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic wake_s;
  logic load_s;

  // Two flops on every pin before any logic looks at it.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      sync_a <= 5'h1E;
      sync_b <= 5'h1E;
    end else if (i_ce) begin
      sync_a <= {i_load_n, i_wake_pin_n, i_sdi, i_cs_n, i_sclk};
      sync_b <= sync_a;
    end
  end

  assign sclk_s = sync_b[0];
  assign cs_s   = sync_b[1];
  assign sdi_s  = sync_b[2];
  assign wake_s = sync_b[3];
  assign load_s = sync_b[4];

  // Delayed copies for edge detection.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
      load_d <= 1'b1;
    end else if (i_ce) begin
      sclk_d <= sclk_s;
      cs_d   <= cs_s;
      load_d <= load_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic load_fall;

  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  assign cs_fall   = ~cs_s & cs_d;
  assign cs_rise   = cs_s & ~cs_d;
  assign load_fall = ~load_s & load_d;

  // ==========================================================
  // Control registers
  // ==========================================================

  logic pass_through;
  logic correction_engine_enable;
  logic cs_wake_enable;

  dac_pkg::code_t channel_code   [CHANNELS];
  dac_pkg::code_t zero_trim_code [CHANNELS];
  dac_pkg::code_t gain_trim_code [CHANNELS];
  dac_pkg::code_t latch_code     [CHANNELS];
  dac_pkg::code_t corrected      [CHANNELS];

  // ==========================================================
  // Frame engine
  // ==========================================================

  dac_pkg::frame_state_t state;

  logic [4:0]  bit_cnt;
  logic [1:0]  fall_cnt;
  logic [23:0] shift_in;
  logic [23:0] shift_out;
  logic [15:0] rd_word;
  logic [15:0] next_rd_word;

  logic        commit;
  logic        wr_en;
  logic        rd_en;
  logic [4:0]  register_select;
  logic [15:0] wr_word;

  // A full frame that ends in normal mode is executed.
  assign commit = cs_rise && (state == dac_pkg::FR_SHIFT) &&
                  (bit_cnt == `FRAME_BITS);
  assign wr_en  = commit && !shift_in[`FRAME_RW_BIT];
  assign rd_en  = commit && shift_in[`FRAME_RW_BIT];
  assign register_select = shift_in[`SEL_HI:`SEL_LO];
  assign wr_word = shift_in[`WORD_HI:0];

  // Frame state follows chip select and the pass-through flag.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state <= dac_pkg::FR_IDLE;
    end else if (i_ce) begin
      case (state)
        dac_pkg::FR_IDLE: begin
          if (cs_fall) begin
            state <= pass_through ? dac_pkg::FR_BYPASS
                                  : dac_pkg::FR_SHIFT;
          end
        end
        dac_pkg::FR_SHIFT: begin
          if (cs_rise) begin
            state <= dac_pkg::FR_IDLE;
          end
        end
        dac_pkg::FR_BYPASS: begin
          if (cs_rise) begin
            state <= dac_pkg::FR_IDLE;
          end
        end
        default: begin
          state <= dac_pkg::FR_IDLE;
        end
      endcase
    end
  end

  // Input shift register runs only in normal mode.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      shift_in <= 24'h000000;
      bit_cnt  <= 5'h00;
    end else if (i_ce) begin
      if (cs_fall) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise && state == dac_pkg::FR_SHIFT) begin
        shift_in <= {shift_in[22:0], sdi_s};
        if (bit_cnt != 5'h1F) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // Falling clock edges per frame, saturating at two.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      fall_cnt <= 2'h0;
    end else if (i_ce) begin
      if (cs_fall) begin
        fall_cnt <= 2'h0;
      end else if (sclk_fall && fall_cnt != `FALL_SAT) begin
        fall_cnt <= fall_cnt + 2'h1;
      end
    end
  end

  // Output shift register carries the word fetched by the last read.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      shift_out <= 24'h000000;
    end else if (i_ce) begin
      if (cs_fall) begin
        shift_out <= {8'h00, rd_word};
      end else if (sclk_fall && state == dac_pkg::FR_SHIFT) begin
        shift_out <= {shift_out[22:0], 1'b0};
      end
    end
  end

  // Serial output: shifted data, or the input itself when bypassed.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (i_ce) begin
      o_sdo_oe <= ~cs_s;
      if (state == dac_pkg::FR_BYPASS) begin
        o_sdo <= sdi_s;
      end else begin
        o_sdo <= shift_out[23];
      end
    end
  end

  // ==========================================================
  // Register writes
  // ==========================================================

  // Pass-through flag with its two ways out.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      pass_through <= 1'b0;
    end else if (i_ce) begin
      if (!wake_s) begin
        pass_through <= 1'b0;
      end else if (wr_en && register_select == `SEL_SERIAL) begin
        pass_through <= wr_word[`PASS_BIT];
      end else if (cs_rise && state == dac_pkg::FR_BYPASS &&
                   cs_wake_enable && fall_cnt <= `FALL_LIMIT) begin
        pass_through <= 1'b0;
      end
    end
  end

  // Configuration bits for correction and chip-select wake.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      correction_engine_enable <= 1'b0;
      cs_wake_enable           <= 1'b0;
    end else if (i_ce) begin
      if (wr_en && register_select == `SEL_CONFIG) begin
        correction_engine_enable <= wr_word[`CEE_BIT];
        cs_wake_enable           <= wr_word[`CSW_BIT];
      end
    end
  end

  // Channel data, zero and gain registers.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channel_code[i]   <= `DATA_RST;
        zero_trim_code[i] <= `ZERO_RST;
        gain_trim_code[i] <= `GAIN_RST;
      end
    end else if (i_ce && wr_en) begin
      if (register_select == `SEL_BCAST) begin
        if (!correction_engine_enable) begin
          for (int i = 0; i < CHANNELS; i++) begin
            channel_code[i] <= wr_word[`CODE_HI:`CODE_LO];
          end
        end
      end else if (register_select[4:3] == `GRP_DATA) begin
        channel_code[register_select[2:0]] <= wr_word[`CODE_HI:`CODE_LO];
      end else if (register_select[4:3] == `GRP_ZERO) begin
        zero_trim_code[register_select[2:0]] <= wr_word[`CODE_HI:`CODE_LO];
      end else if (register_select[4:3] == `GRP_GAIN) begin
        gain_trim_code[register_select[2:0]] <= wr_word[`CODE_HI:`CODE_LO];
      end
    end
  end

  // ==========================================================
  // Register reads
  // ==========================================================

  // Read value for the selected register; unmapped reads zero.
  always_comb begin
    next_rd_word = `WORD_ZERO;
    if (register_select == `SEL_CONFIG) begin
      next_rd_word[`CEE_BIT] = correction_engine_enable;
      next_rd_word[`CSW_BIT] = cs_wake_enable;
    end else if (register_select == `SEL_SERIAL) begin
      next_rd_word[`PASS_BIT] = pass_through;
    end else if (register_select == `SEL_BCAST) begin
      next_rd_word = `WORD_ZERO;
    end else if (register_select[4:3] == `GRP_DATA) begin
      next_rd_word[`CODE_HI:`CODE_LO] = channel_code[register_select[2:0]];
    end else if (register_select[4:3] == `GRP_ZERO) begin
      next_rd_word[`CODE_HI:`CODE_LO] = zero_trim_code[register_select[2:0]];
    end else if (register_select[4:3] == `GRP_GAIN) begin
      next_rd_word[`CODE_HI:`CODE_LO] = gain_trim_code[register_select[2:0]];
    end
  end

  // The fetched word waits for the next frame.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rd_word <= `WORD_ZERO;
    end else if (i_ce && rd_en) begin
      rd_word <= next_rd_word;
    end
  end

  // ==========================================================
  // Correction and output latches
  // ==========================================================

  // One corrector per channel; bypassed while correction is off.
  for (genvar g = 0; g < CHANNELS; g++) begin : g_corr
    code_corrector u_corr (
      .i_code   (channel_code[g]),
      .i_gain   (gain_trim_code[g]),
      .i_zero   (zero_trim_code[g]),
      .i_enable (correction_engine_enable),
      .o_code   (corrected[g])
    );
  end

  // Load pin falling edge moves every channel into its latch.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        latch_code[i] <= `DATA_RST;
      end
    end else if (i_ce && load_fall) begin
      for (int i = 0; i < CHANNELS; i++) begin
        latch_code[i] <= corrected[i];
      end
    end
  end

  // Flatten latches onto the output port, channel 0 lowest.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_latch_code   <= '0;
      o_pass_through <= 1'b0;
    end else if (i_ce) begin
      o_pass_through <= pass_through;
      for (int i = 0; i < CHANNELS; i++) begin
        o_latch_code[i*CODE_W +: CODE_W] <= latch_code[i];
      end
    end
  end

endmodule // dac_ctrl

`default_nettype wire

// file: rtl/dac_map.svh
// Register map, field positions and reset values of the converter control block.
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

// Frame layout of the serial word.
`define FRAME_BITS    5'h18
`define FRAME_RW_BIT  23
`define SEL_HI        20
`define SEL_LO        16
`define WORD_HI       15

// Register select values.
`define SEL_CONFIG    5'h00
`define SEL_SERIAL    5'h03
`define SEL_BCAST     5'h07
`define GRP_DATA      2'h1
`define GRP_ZERO      2'h2
`define GRP_GAIN      2'h3

// Field positions.
`define CODE_HI       15
`define CODE_LO       2
`define PASS_BIT      15
`define CEE_BIT       8
`define CSW_BIT       4

// Reset values and fixed constants.
`define DATA_RST      14'h0000
`define ZERO_RST      14'h0000
`define GAIN_RST      14'h2000
`define GAIN_UNITY    15'h2000
`define WORD_ZERO     16'h0000
`define FALL_LIMIT    2'h1
`define FALL_SAT      2'h2

`endif

// file: rtl/dac_pkg.sv
// Types shared by the converter control block.
`default_nettype none
package dac_pkg;

  typedef enum logic [1:0] {
    FR_IDLE   = 2'b00,
    FR_SHIFT  = 2'b01,
    FR_BYPASS = 2'b10
  } frame_state_t;

  typedef logic [13:0] code_t;

endpackage

`default_nettype wire

// file: rtl/code_corrector.sv
// One channel of gain and zero correction with saturation.
`timescale 1ns/1ps
`default_nettype none
`include "dac_map.svh"

module code_corrector (
  input  wire logic [13:0] i_code,
  input  wire logic [13:0] i_gain,
  input  wire logic [13:0] i_zero,
  input  wire logic        i_enable,
  output logic      [13:0] o_code
);

  logic [14:0] coef;
  logic [28:0] prod;
  logic [16:0] sum;

  // Coefficient is one half plus gain code over 2^14.
  assign coef = {1'b0, i_gain} + `GAIN_UNITY;
  assign prod = i_code * coef;
  assign sum  = {2'b00, prod[28:14]} + {{3{i_zero[13]}}, i_zero};

  // Saturate to the unsigned 14-bit code range.
  always_comb begin
    if (!i_enable) begin
      o_code = i_code;
    end else if (sum[16]) begin
      o_code = 14'h0000;
    end else if (sum[15:14] != 2'b00) begin
      o_code = 14'h3FFF;
    end else begin
      o_code = sum[13:0];
    end
  end

endmodule // code_corrector

`default_nettype wire

// file: test/spi_host_model.sv
// Host-side serial master that frames register traffic for the control block.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi
);
  // ==========
  // Idle levels: clock still and low, device deselected.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b1;
  end
  // Sends nbits of tx MSB first, half sys clocks per phase, and samples sdo after each rise.
  task automatic xfer(input logic [23:0] tx, input int nbits, input int half, output logic [23:0] rx);
    rx = 24'h000000;
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int b = 23; b > 23 - nbits; b--) begin
      o_sdi = tx[b];
      repeat (half) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (2) @(negedge i_clk);
      rx = {rx[22:0], i_sdo};
      repeat (half - 2) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (half) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi; // Released line shows the inverse of its last value.
    repeat (10) @(negedge i_clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// file: test/dac_ctrl_checker.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_checker #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 14
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_rstn,
  input wire logic                       i_cs_n,
  input wire logic                       i_sdi,
  input wire logic                       i_wake_pin_n,
  input wire logic                       i_load_n,
  input wire logic                       o_sdo,
  input wire logic                       o_sdo_oe,
  input wire logic                       o_pass_through,
  input wire logic [CHANNELS*CODE_W-1:0] o_latch_code
);
  logic       load_q;
  logic       cs_q;
  logic [3:0] since_load;
  logic [3:0] since_cs;
  logic [3:0] since_wake;
  // ==========
  // Saturating cycle counts since a load fall and a chip-select rise.
  always_ff @(posedge i_clk_sys) begin
    load_q <= i_load_n;
    cs_q   <= i_cs_n;
    if (!i_rstn) begin
      since_load <= 4'hF;
      since_cs   <= 4'hF;
    end else begin
      since_load <= (load_q && !i_load_n) ? 4'h0 : since_load + {3'h0, since_load != 4'hF};
      since_cs   <= (!cs_q && i_cs_n) ? 4'h0 : since_cs + {3'h0, since_cs != 4'hF};
    end
  end
  // Saturating cycle count since the wake pin was last low.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) since_wake <= 4'hF;
    else since_wake <= !i_wake_pin_n ? 4'h0 : since_wake + {3'h0, since_wake != 4'hF};
  end
  // ==========
  // Assertions.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  chk_reset_clears: assert property (disable iff (1'b0)
    !i_rstn |=> !o_pass_through && !o_sdo_oe && o_latch_code == '0) else $error("reset left outputs set");
  chk_wake_holds: assert property ((!i_wake_pin_n) [*6] |-> !o_pass_through)
    else $error("pass-through set while wake pin low");
  chk_pass_rise: assert property ($rose(o_pass_through) |-> since_cs <= 4'h8)
    else $error("pass-through set outside a frame end");
  chk_pass_fall: assert property ($fell(o_pass_through) |-> since_cs <= 4'h8 || since_wake <= 4'h8)
    else $error("pass-through cleared without cause");
  chk_pass_route: assert property ((o_pass_through && !i_cs_n && $stable(i_sdi)) [*6] |-> o_sdo == i_sdi)
    else $error("serial input not routed to output");
  chk_oe_active: assert property ((!i_cs_n) [*5] |-> o_sdo_oe)
    else $error("output not driven in frame");
  chk_oe_idle: assert property (i_cs_n [*5] |-> !o_sdo_oe)
    else $error("output driven while deselected");
  chk_latch_cause: assert property ($changed(o_latch_code) |-> since_load <= 4'h8)
    else $error("latch changed without load");
  cover property ($rose(o_pass_through));
  cover property ($fell(o_pass_through) && i_wake_pin_n);
  cover property ($changed(o_latch_code));
endmodule // dac_ctrl_checker
bind dac_ctrl dac_ctrl_checker #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_dac_ctrl_checker (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_wake_pin_n(i_wake_pin_n),
  .i_load_n(i_load_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_pass_through(o_pass_through),
  .o_latch_code(o_latch_code)
);
`default_nettype wire

// file: test/dac_ctrl_tb_top.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module dac_ctrl_tb_top;
  logic         i_clk_sys = 1'b0;
  logic         i_rstn;
  logic         i_load_n;
  logic         i_wake_pin_n;
  logic         sclk;
  logic         cs_n;
  logic         sdi;
  logic         o_sdo;
  logic         o_sdo_oe;
  logic         o_pass_through;
  logic [111:0] o_latch_code;
  logic [13:0]  code [8];
  logic [13:0]  zero [8];
  logic [13:0]  gain [8];
  logic [31:0]  seed;
  logic [23:0]  rx;
  logic [23:0]  tx;
  logic [15:0]  w;
  int           n_fail = 0;
  int           total_checks = 0;
  // ==========
  // 100 MHz system clock, design under test and host.
  always #5 i_clk_sys = ~i_clk_sys;
  dac_ctrl u_dac_ctrl (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(1'b1), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_wake_pin_n(i_wake_pin_n), .i_load_n(i_load_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_pass_through(o_pass_through), .o_latch_code(o_latch_code)
  );
  spi_host_model u_spi_host_model (.i_clk(i_clk_sys), .i_sdo(o_sdo), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
  // ==========
  // Helpers: random source, corrected code, register and load traffic.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [13:0] corr(logic [13:0] c, logic [13:0] g, logic [13:0] z);
    longint v;
    v = ((longint'(c) * (longint'(g) + 64'sh2000)) >>> 14) + longint'(signed'(z));
    if (v < 0) return 14'h0000;
    if (v > 64'sh3FFF) return 14'h3FFF;
    return v[13:0];
  endfunction
  task automatic wr(input logic [4:0] sel, input logic [15:0] d);
    u_spi_host_model.xfer({3'b000, sel, d}, 24, 4, rx);
  endtask
  // Read data comes back in the following frame, a slow dummy read.
  task automatic rd(input logic [4:0] sel, output logic [15:0] d);
    u_spi_host_model.xfer({3'b100, sel, 16'h0000}, 24, 4, rx);
    u_spi_host_model.xfer({3'b100, 5'h07, 16'h0000}, 24, 6, rx);
    d = rx[15:0];
    `CHECK(rx[23:16], 8'h00)
  endtask
  task automatic rd3(input int i, input logic [15:0] d, input logic [15:0] z, input logic [15:0] g);
    rd(5'(8 + i), w);
    `CHECK(w, d)
    rd(5'(16 + i), w);
    `CHECK(w, z)
    rd(5'(24 + i), w);
    `CHECK(w, g)
  endtask
  task automatic ld(input logic on);
    i_load_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    i_load_n = 1'b1;
    repeat (8) @(negedge i_clk_sys);
    for (int i = 0; i < 8; i++) begin
      `CHECK(o_latch_code[14*i +: 14], on ? corr(code[i], gain[i], zero[i]) : code[i])
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short well above the expected run length.
  initial begin
    repeat (80000) @(posedge i_clk_sys);
    n_fail++;
    summarize();
  end
  // ==========
  // Main sequence.
  initial begin
    seed = 32'hBA67343B;
    i_rstn = 1'b0;
    i_load_n = 1'b1;
    i_wake_pin_n = 1'b1;
    repeat (12) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    for (int i = 0; i < 8; i++) rd3(i, 16'h0000, 16'h0000, 16'h8000);
    for (int i = 0; i < 8; i++) begin
      code[i] = i == 0 ? 14'h3FFF : 14'(rnd());
      zero[i] = i == 1 ? 14'h2000 : (i == 0 ? 14'h0001 : 14'(rnd()));
      gain[i] = i == 0 ? 14'h3FFF : 14'(rnd());
      wr(5'(8 + i), {code[i], 2'(rnd())});
      wr(5'(16 + i), {zero[i], 2'b11});
      wr(5'(24 + i), {gain[i], 2'b01});
    end
    for (int i = 0; i < 8; i++) rd3(i, {code[i], 2'b00}, {zero[i], 2'b00}, {gain[i], 2'b00});
    // A frame one bit short must leave the register alone.
    u_spi_host_model.xfer(24'h100000, 23, 4, rx);
    ld(1'b0);
    wr(5'h00, 16'h0100);
    ld(1'b1);
    // Broadcast is dropped with correction on and taken with it off.
    tx = 24'(rnd());
    wr(5'h07, tx[15:0]);
    ld(1'b1);
    // Chip-select wake is ignored while its enable bit is off.
    wr(5'h03, 16'h8000);
    u_spi_host_model.xfer(24'h000000, 1, 4, rx);
    `CHECK(o_pass_through, 1'b1)
    i_wake_pin_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    `CHECK(o_pass_through, 1'b0)
    i_wake_pin_n = 1'b1;
    wr(5'h00, 16'h0010);
    wr(5'h07, tx[15:0]);
    rd(5'h07, w);
    `CHECK(w, 16'h0000)
    for (int i = 0; i < 8; i++) code[i] = tx[15:2];
    ld(1'b0);
    // Pass-through entry, routing, chip-select wake and wake pin.
    wr(5'h03, 16'h8000);
    `CHECK(o_pass_through, 1'b1)
    tx = 24'(rnd());
    u_spi_host_model.xfer(tx, 24, 4, rx);
    `CHECK(rx, tx)
    u_spi_host_model.xfer(24'hFFFFFF, 2, 4, rx);
    `CHECK(o_pass_through, 1'b1)
    u_spi_host_model.xfer(24'h000000, 1, 4, rx);
    `CHECK(o_pass_through, 1'b0)
    wr(5'h03, 16'h8000);
    i_wake_pin_n = 1'b0;
    repeat (8) @(negedge i_clk_sys);
    `CHECK(o_pass_through, 1'b0)
    wr(5'h03, 16'h8000);
    `CHECK(o_pass_through, 1'b0)
    i_wake_pin_n = 1'b1;
    wr(5'h03, 16'h8000);
    `CHECK(o_pass_through, 1'b1)
    i_rstn = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    `CHECK(o_pass_through, 1'b0)
    `CHECK(o_latch_code, 112'h0)
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    rd3(7, 16'h0000, 16'h0000, 16'h8000);
    summarize();
  end
endmodule // dac_ctrl_tb_top
`default_nettype wire
